// ### rtl/ptu_paging_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptu_params.svh"

module ptu_paging_unit
	import ptu_pkg::*;
#(
	parameter int TLB_ENTRIES = `PTU_TLB_ENTRIES,
	parameter int TLB_WAYS    = `PTU_TLB_WAYS
) (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	// Segmentation side
	input  wire logic        req_valid_i,
	input  wire logic [31:0] req_lin_i,
	input  wire logic        req_write_i,
	input  wire logic        req_user_i,
	output logic             req_ready_o,
	output logic             rsp_valid_o,
	output logic [31:0]      rsp_phys_o,
	output logic             rsp_fault_o,
	output logic [7:0]       rsp_vector_o,
	output logic [15:0]      rsp_err_o,
	// Control register access
	input  wire logic        cr_wr_i,
	input  wire ptu_cr_sel_e cr_sel_i,
	input  wire logic [31:0] cr_wdata_i,
	output logic [31:0]      fault_lin_o,
	output logic [31:0]      dir_base_o,
	// Bus unit side
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic             mem_lock_o,
	output logic [31:0]      mem_addr_o,
	output logic [31:0]      mem_wdata_o,
	input  wire logic        mem_ack_i,
	input  wire logic [31:0] mem_rdata_i
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Entry word address: 4K-aligned base plus ten-bit index
	function automatic logic [31:0] entry_addr(
		input logic [19:0] base,
		input logic [9:0]  idx
	);
		entry_addr = {base, idx, 2'b00};
	endfunction : entry_addr

	// Most restrictive pair is the numerically smaller one
	function automatic logic [1:0] prot_min(
		input logic [1:0] a,
		input logic [1:0] b
	);
		prot_min = (a < b) ? a : b;
	endfunction : prot_min

	// Rights check; supervisor accesses always pass
	function automatic logic prot_ok(
		input logic [1:0] us_rw,
		input logic       user,
		input logic       write
	);
		prot_ok = !user || (us_rw[1] && (!write || us_rw[0]));
	endfunction : prot_ok

	// Protection pair of an entry: bit 2 then bit 1
	function automatic logic [1:0] prot_of(
		input logic [31:0] entry
	);
		prot_of = {entry[`PTU_BIT_US], entry[`PTU_BIT_RW]};
	endfunction : prot_of

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ptu_state_e  state_r;
	logic [31:0] lin_r;
	logic        wr_r;
	logic        user_r;
	logic [31:0] pde_r;

	logic        tlb_hit;
	logic [19:0] tlb_frame;
	logic [1:0]  tlb_prot;
	logic        tlb_dirty;
	logic        flush;
	logic        fill;
	logic [31:0] fill_pte;

	logic        ack;
	logic        rd_present;
	logic [1:0]  walk_prot;
	logic        walk_ok;
	logic        pte_upd;
	logic        hit_done;
	logic        hit_fault;
	logic        np_fault;
	logic        pr_fault;
	logic        any_fault;
	logic        walk_done;
	logic [31:0] pde_set_a;
	logic [31:0] pte_set_ad;

	// ----------------------------------------------------------------
	// Decode of the current walk step
	// ----------------------------------------------------------------
	// An acknowledge only counts while a request is out
	assign ack        = ce_i && mem_ack_i && mem_req_o;
	// Only bit 0 is looked at until the entry is known present
	assign rd_present = mem_rdata_i[`PTU_BIT_PRESENT];
	// Rights are judged on the combined pair of both levels
	assign walk_prot  = prot_min(prot_of(pde_r), prot_of(mem_rdata_i));
	assign walk_ok    = prot_ok(walk_prot, user_r, wr_r);
	// Table entry needs a write-back when A or a needed D is clear
	assign pte_upd    = !mem_rdata_i[`PTU_BIT_ACCESSED] ||
	                    (wr_r && !mem_rdata_i[`PTU_BIT_DIRTY]);

	// Only the two flag bits are ORed in; bits 9..11 pass untouched
	assign pde_set_a  = mem_rdata_i | (32'h0000_0001 << `PTU_BIT_ACCESSED);
	assign pte_set_ad = mem_rdata_i | (32'h0000_0001 << `PTU_BIT_ACCESSED) |
	                    ({31'h0000_0000, wr_r} << `PTU_BIT_DIRTY);

	// Outcomes: a hit that needs D set takes the walk again
	assign hit_done  = (state_r == PTU_S_LOOK) && tlb_hit &&
	                   prot_ok(tlb_prot, user_r, wr_r) && (!wr_r || tlb_dirty);
	assign hit_fault = ce_i && (state_r == PTU_S_LOOK) && tlb_hit &&
	                   !prot_ok(tlb_prot, user_r, wr_r);
	assign np_fault  = ack && !rd_present &&
	                   (state_r == PTU_S_DIR_RD || state_r == PTU_S_TBL_RD);
	assign pr_fault  = ack && rd_present && (state_r == PTU_S_TBL_RD) && !walk_ok;
	assign any_fault = hit_fault || np_fault || pr_fault;
	assign walk_done = ack && ((state_r == PTU_S_TBL_WR) ||
	                   ((state_r == PTU_S_TBL_RD) && rd_present && walk_ok &&
	                    !pte_upd));

	// Fill with the entry as it now stands in memory
	assign fill     = walk_done;
	assign fill_pte = (state_r == PTU_S_TBL_WR) ? mem_wdata_o : mem_rdata_i;
	assign flush    = ce_i && cr_wr_i && (cr_sel_i == PTU_CR_DIR_BASE);

	// ----------------------------------------------------------------
	// Translation buffer
	// ----------------------------------------------------------------
	ptu_tlb #(
		.ENTRIES (TLB_ENTRIES),
		.WAYS    (TLB_WAYS)
	) u_tlb (
		.clk_i        (clk_i),
		.rstn_i       (rstn_i),
		.ce_i         (ce_i),
		.flush_i      (flush),
		.lk_vpn_i     (lin_r[31:`PTU_PAGE_BITS]),
		.hit_o        (tlb_hit),
		.frame_o      (tlb_frame),
		.prot_o       (tlb_prot),
		.dirty_o      (tlb_dirty),
		.fill_i       (fill),
		.fill_frame_i (fill_pte[31:`PTU_PAGE_BITS]),
		.fill_prot_i  (prot_min(prot_of(pde_r), prot_of(fill_pte))),
		.fill_dirty_i (fill_pte[`PTU_BIT_DIRTY])
	);

	// ----------------------------------------------------------------
	// Walk sequencer and bus requests
	// ----------------------------------------------------------------
	// Every table read is locked so a flag write-back can follow
	// without another master slipping in between.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_r     <= PTU_S_IDLE;
			req_ready_o <= 1'b1;
			lin_r       <= `PTU_WORD_ZERO;
			wr_r        <= 1'b0;
			user_r      <= 1'b0;
			pde_r       <= `PTU_WORD_ZERO;
			mem_req_o   <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_lock_o  <= 1'b0;
			mem_addr_o  <= `PTU_WORD_ZERO;
			mem_wdata_o <= `PTU_WORD_ZERO;
		end else if (ce_i) begin
			case (state_r)
			PTU_S_IDLE: begin
				// Latch the request; ready falls until the answer
				if (req_valid_i) begin
					lin_r       <= req_lin_i;
					wr_r        <= req_write_i;
					user_r      <= req_user_i;
					req_ready_o <= 1'b0;
					state_r     <= PTU_S_LOOK;
				end
			end
			PTU_S_LOOK: begin
				// A write hit on a clean page falls through to a walk
				if (hit_done || hit_fault) begin
					req_ready_o <= 1'b1;
					state_r     <= PTU_S_IDLE;
				end else begin
					mem_req_o  <= 1'b1;
					mem_we_o   <= 1'b0;
					mem_lock_o <= 1'b1;
					mem_addr_o <= entry_addr(dir_base_o[31:`PTU_PAGE_BITS],
					                         lin_r[31:`PTU_DIR_LSB]);
					state_r    <= PTU_S_DIR_RD;
				end
			end
			PTU_S_DIR_RD: begin
				// Present with A clear costs an extra locked write
				if (mem_ack_i) begin
					pde_r <= mem_rdata_i;
					if (!rd_present) begin
						mem_req_o   <= 1'b0;
						mem_lock_o  <= 1'b0;
						req_ready_o <= 1'b1;
						state_r     <= PTU_S_IDLE;
					end else if (!mem_rdata_i[`PTU_BIT_ACCESSED]) begin
						mem_we_o    <= 1'b1;
						mem_wdata_o <= pde_set_a;
						state_r     <= PTU_S_DIR_WR;
					end else begin
						mem_addr_o <= entry_addr(mem_rdata_i[31:`PTU_PAGE_BITS],
						                         lin_r[21:`PTU_TBL_LSB]);
						state_r    <= PTU_S_TBL_RD;
					end
				end
			end
			PTU_S_DIR_WR: begin
				if (mem_ack_i) begin
					// Lock stays held on into the table entry's own cycle pair
					mem_we_o   <= 1'b0;
					mem_addr_o <= entry_addr(pde_r[31:`PTU_PAGE_BITS],
					                         lin_r[21:`PTU_TBL_LSB]);
					state_r    <= PTU_S_TBL_RD;
				end
			end
			PTU_S_TBL_RD: begin
				// Faults and already-flagged entries end here
				if (mem_ack_i) begin
					if (rd_present && walk_ok && pte_upd) begin
						mem_we_o    <= 1'b1;
						mem_wdata_o <= pte_set_ad;
						state_r     <= PTU_S_TBL_WR;
					end else begin
						mem_req_o   <= 1'b0;
						mem_lock_o  <= 1'b0;
						req_ready_o <= 1'b1;
						state_r     <= PTU_S_IDLE;
					end
				end
			end
			PTU_S_TBL_WR: begin
				// Write-back done; the lock drops with the request
				if (mem_ack_i) begin
					mem_req_o   <= 1'b0;
					mem_we_o    <= 1'b0;
					mem_lock_o  <= 1'b0;
					req_ready_o <= 1'b1;
					state_r     <= PTU_S_IDLE;
				end
			end
			default: begin
				// Stray code: drop the bus and go idle
				mem_req_o   <= 1'b0;
				mem_lock_o  <= 1'b0;
				req_ready_o <= 1'b1;
				state_r     <= PTU_S_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Response to the segmentation side
	// ----------------------------------------------------------------
	// One-cycle answer; the physical address holds until the next one
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rsp_valid_o  <= 1'b0;
			rsp_phys_o   <= `PTU_WORD_ZERO;
			rsp_fault_o  <= 1'b0;
		end else if (ce_i) begin
			rsp_valid_o <= hit_done || walk_done || any_fault;
			rsp_fault_o <= any_fault;
			if (hit_done) begin
				rsp_phys_o <= {tlb_frame, lin_r[11:0]};
			end else if (walk_done) begin
				rsp_phys_o <= {fill_pte[31:`PTU_PAGE_BITS], lin_r[11:0]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Fault report
	// ----------------------------------------------------------------
	// Vector and code hold from one fault to the next, so a handler
	// still reads the cause after later clean answers.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rsp_vector_o <= 8'h00;
			rsp_err_o    <= 16'h0000;
		end else if (ce_i && any_fault) begin
			rsp_vector_o <= `PTU_FAULT_VECTOR;
			rsp_err_o    <= 16'h0000;
			rsp_err_o[`PTU_ERR_PROT]  <= hit_fault || pr_fault;
			rsp_err_o[`PTU_ERR_WRITE] <= wr_r;
			rsp_err_o[`PTU_ERR_USER]  <= user_r;
		end
	end

	// ----------------------------------------------------------------
	// Fault linear address register
	// ----------------------------------------------------------------
	// A fault in the same cycle as a software write wins, so the
	// address of a fresh fault is never lost.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			fault_lin_o <= `PTU_WORD_ZERO;
		end else if (ce_i) begin
			if (any_fault) begin
				fault_lin_o <= lin_r;
			end else if (cr_wr_i && cr_sel_i == PTU_CR_FAULT_ADDR) begin
				fault_lin_o <= cr_wdata_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Directory base register
	// ----------------------------------------------------------------
	// Low bits are forced to zero rather than stored
	// The same strobe flushes the buffer, so no stale entry outlives it
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			dir_base_o <= `PTU_WORD_ZERO;
		end else if (flush) begin
			dir_base_o <= {cr_wdata_i[31:`PTU_PAGE_BITS], `PTU_LOW_ZERO};
		end
	end

endmodule : ptu_paging_unit
`default_nettype wire

// ### rtl/ptu_params.svh
`ifndef PTU_PARAMS_SVH
`define PTU_PARAMS_SVH

// ----------------------------------------------------------------
// Entry layout
// ----------------------------------------------------------------
`define PTU_BIT_PRESENT   0
`define PTU_BIT_RW        1
`define PTU_BIT_US        2
`define PTU_BIT_ACCESSED  5
`define PTU_BIT_DIRTY     6
`define PTU_PAGE_BITS     12
`define PTU_DIR_LSB       22
`define PTU_TBL_LSB       12
`define PTU_LOW_ZERO      12'h000
`define PTU_WORD_ZERO     32'h0000_0000

// ----------------------------------------------------------------
// Fault reporting
// ----------------------------------------------------------------
`define PTU_FAULT_VECTOR  8'h0e
`define PTU_ERR_PROT      0
`define PTU_ERR_WRITE     1
`define PTU_ERR_USER      2

// ----------------------------------------------------------------
// Buffer geometry
// ----------------------------------------------------------------
`define PTU_TLB_ENTRIES   32
`define PTU_TLB_WAYS      4

`endif

// ### rtl/ptu_pkg.sv
package ptu_pkg;

	// Walk states, one-hot
	typedef enum logic [5:0] {
		PTU_S_IDLE   = 6'b00_0001,
		PTU_S_LOOK   = 6'b00_0010,
		PTU_S_DIR_RD = 6'b00_0100,
		PTU_S_DIR_WR = 6'b00_1000,
		PTU_S_TBL_RD = 6'b01_0000,
		PTU_S_TBL_WR = 6'b10_0000
	} ptu_state_e;

	// Control register selector
	typedef enum logic {
		PTU_CR_FAULT_ADDR = 1'b0,
		PTU_CR_DIR_BASE   = 1'b1
	} ptu_cr_sel_e;

endpackage : ptu_pkg

// ### rtl/ptu_tlb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptu_params.svh"

module ptu_tlb
	import ptu_pkg::*;
#(
	parameter int ENTRIES = `PTU_TLB_ENTRIES,
	parameter int WAYS    = `PTU_TLB_WAYS
) (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	input  wire logic        flush_i,
	input  wire logic [19:0] lk_vpn_i,
	output logic             hit_o,
	output logic [19:0]      frame_o,
	output logic [1:0]       prot_o,
	output logic             dirty_o,
	input  wire logic        fill_i,
	input  wire logic [19:0] fill_frame_i,
	input  wire logic [1:0]  fill_prot_i,
	input  wire logic        fill_dirty_i
);

	localparam int SETS  = ENTRIES / WAYS;
	localparam int SET_W = $clog2(SETS);
	localparam int WAY_W = $clog2(WAYS);
	localparam int TAG_W = 20 - SET_W;

	logic [WAYS-1:0]  valid_r  [SETS];
	logic [TAG_W-1:0] tag_r    [SETS][WAYS];
	logic [19:0]      frame_r  [SETS][WAYS];
	logic [1:0]       prot_r   [SETS][WAYS];
	logic             dirty_r  [SETS][WAYS];
	logic [WAY_W-1:0] victim_r [SETS];
	logic [WAY_W-1:0] hit_way;
	logic [WAY_W-1:0] fill_way;
	logic [SET_W-1:0] set_idx;
	logic [TAG_W-1:0] tag;

	assign set_idx = lk_vpn_i[SET_W-1:0];
	assign tag     = lk_vpn_i[19:SET_W];

	// ----------------------------------------------------------------
	// Lookup: upper linear bits compared across the set's ways
	// ----------------------------------------------------------------
	always_comb begin
		hit_o   = 1'b0;
		hit_way = '0;
		for (int w = 0; w < WAYS; w++) begin
			if (valid_r[set_idx][w] && tag_r[set_idx][w] == tag) begin
				hit_o   = 1'b1;
				hit_way = WAY_W'(w);
			end
		end
		frame_o = frame_r[set_idx][hit_way];
		prot_o  = prot_r[set_idx][hit_way];
		dirty_o = dirty_r[set_idx][hit_way];
	end

	// Refresh in place on a re-walk so no tag is held twice
	assign fill_way = hit_o ? hit_way : victim_r[set_idx];

	// ----------------------------------------------------------------
	// Valid bits and round-robin victims; flush beats a fill
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			for (int s = 0; s < SETS; s++) begin
				valid_r[s]  <= '0;
				victim_r[s] <= '0;
			end
		end else if (ce_i) begin
			if (flush_i) begin
				for (int s = 0; s < SETS; s++) begin
					valid_r[s] <= '0;
				end
			end else if (fill_i) begin
				valid_r[set_idx][fill_way] <= 1'b1;
				if (!hit_o) begin
					victim_r[set_idx] <= victim_r[set_idx] + 1'b1;
				end
			end
		end
	end

	// Entry payload needs no reset; valid bits guard it
	always_ff @(posedge clk_i) begin
		if (ce_i && fill_i) begin
			tag_r[set_idx][fill_way]   <= tag;
			frame_r[set_idx][fill_way] <= fill_frame_i;
			prot_r[set_idx][fill_way]  <= fill_prot_i;
			dirty_r[set_idx][fill_way] <= fill_dirty_i;
		end
	end

endmodule : ptu_tlb
`default_nettype wire

// ### verif/ptu_paging_unit_props.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker for the paging unit
// ----------------------------------------
module ptu_paging_unit_props
	import ptu_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        ce_i,
	input wire logic        req_valid_i,
	input wire logic [31:0] req_lin_i,
	input wire logic        req_write_i,
	input wire logic        req_user_i,
	input wire logic        req_ready_o,
	input wire logic        rsp_valid_o,
	input wire logic [31:0] rsp_phys_o,
	input wire logic        rsp_fault_o,
	input wire logic [7:0]  rsp_vector_o,
	input wire logic [15:0] rsp_err_o,
	input wire logic        cr_wr_i,
	input wire ptu_cr_sel_e cr_sel_i,
	input wire logic [31:0] cr_wdata_i,
	input wire logic [31:0] fault_lin_o,
	input wire logic [31:0] dir_base_o,
	input wire logic        mem_req_o,
	input wire logic        mem_we_o,
	input wire logic        mem_lock_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [31:0] mem_wdata_o,
	input wire logic        mem_ack_i,
	input wire logic [31:0] mem_rdata_i
);
	logic [31:0] lin_q, rd_q, ra_q;
	logic        wr_q, us_q;
	wire         take = ce_i && req_valid_i && req_ready_o;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// Remember the request in flight and the last entry read
	always_ff @(posedge clk_i) begin
		if (take) begin
			lin_q <= req_lin_i;
			wr_q  <= req_write_i;
			us_q  <= req_user_i;
		end
		if (mem_ack_i && !mem_we_o) begin
			rd_q <= mem_rdata_i;
			ra_q <= mem_addr_o;
		end
	end

	low_zero_a: assert property (dir_base_o[11:0] == 12'h000)
		else $error("directory base low bits not zero");
	base_load_a: assert property (ce_i && cr_wr_i
		&& cr_sel_i == PTU_CR_DIR_BASE
		|=> dir_base_o == ($past(cr_wdata_i) & 32'hffff_f000))
		else $error("directory base not loaded");
	fault_addr_a: assert property (rsp_valid_o && rsp_fault_o
		|=> fault_lin_o == $past(lin_q))
		else $error("fault address not captured");
	phys_join_a: assert property (rsp_valid_o && !rsp_fault_o
		|-> rsp_phys_o[11:0] == lin_q[11:0])
		else $error("offset bits not carried");
	err_code_a: assert property (rsp_valid_o && rsp_fault_o
		|-> rsp_err_o[15:1] == {13'h0000, us_q, wr_q}
		&& rsp_vector_o == 8'h0e)
		else $error("fault code wrong");
	lock_wr_a: assert property (mem_req_o && mem_we_o |-> mem_lock_o)
		else $error("flag update not locked");
	rmw_same_a: assert property (mem_req_o && mem_we_o
		|-> mem_addr_o == ra_q && mem_wdata_o[5]
		&& (mem_wdata_o | 32'h0000_0060) == (rd_q | 32'h0000_0060))
		else $error("flag update alters other bits");
	bus_hold_a: assert property (mem_req_o && !mem_ack_i
		|=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o)
		&& $stable(mem_wdata_o))
		else $error("bus request dropped or changed");
	answer_a: assert property (take |=> !req_ready_o ##[1:40] rsp_valid_o)
		else $error("no answer to request");

	hit_c: cover property (take ##2 rsp_valid_o);
	prot_c: cover property (rsp_valid_o && rsp_fault_o && rsp_err_o[0]);
	rmw_c: cover property (mem_req_o && mem_we_o && mem_ack_i);
endmodule : ptu_paging_unit_props

bind ptu_paging_unit ptu_paging_unit_props u_props (
	.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
	.req_valid_i(req_valid_i), .req_lin_i(req_lin_i),
	.req_write_i(req_write_i), .req_user_i(req_user_i),
	.req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
	.rsp_phys_o(rsp_phys_o), .rsp_fault_o(rsp_fault_o),
	.rsp_vector_o(rsp_vector_o), .rsp_err_o(rsp_err_o),
	.cr_wr_i(cr_wr_i), .cr_sel_i(cr_sel_i), .cr_wdata_i(cr_wdata_i),
	.fault_lin_o(fault_lin_o), .dir_base_o(dir_base_o),
	.mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_lock_o(mem_lock_o),
	.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
	.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i)
);
`default_nettype wire

// ### verif/ptu_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Bus unit and table memory
// ----------------------------------------
module ptu_mem_model (
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        mem_req_i,
	input wire logic        mem_we_i,
	input wire logic [31:0] mem_addr_i,
	input wire logic [31:0] mem_wdata_i,
	output logic            mem_ack_o,
	output logic [31:0]     mem_rdata_o
);
	logic [31:0] m [0:16383];
	logic [1:0]  wt, dl;

	// Waits rotate 0..3 cycles so prompt and slow answers both occur
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			mem_ack_o   <= 1'b0;
			mem_rdata_o <= 32'h0000_0000;
			wt          <= 2'h0;
			dl          <= 2'h0;
		end else if (mem_ack_o) begin
			mem_ack_o   <= 1'b0;
			mem_rdata_o <= ~mem_rdata_o; // Bus released: old word gone
		end else if (mem_req_i && wt != 2'h0) begin
			wt <= wt - 2'h1;
		end else if (mem_req_i) begin
			mem_ack_o <= 1'b1;
			wt        <= dl;
			dl        <= dl + 2'h1;
			if (mem_we_i)
				m[mem_addr_i[15:2]] <= mem_wdata_i;
			else
				mem_rdata_o <= m[mem_addr_i[15:2]];
		end
	end
endmodule : ptu_mem_model
`default_nettype wire

// ### verif/two_level_page_translation_tlb_tb.sv
`timescale 1ns/100ps
`default_nettype none
module two_level_page_translation_tlb_tb
	import ptu_pkg::*;
;
	typedef struct packed {logic f; logic [31:0] p; logic [15:0] e;} ptu_note_s;
	ptu_note_s   q[$];
	ptu_note_s   nt;
	int          error_cnt, comparisons, seed, cyc, n;
	logic        clk_i, rstn_i, req_valid_i, req_write_i, req_user_i, cr_wr_i;
	logic [31:0] req_lin_i, cr_wdata_i, lin, frm;
	ptu_cr_sel_e cr_sel_i;
	logic        req_ready_o, rsp_valid_o, rsp_fault_o, mem_req_o, mem_we_o;
	logic        mem_lock_o, mem_ack_i;
	logic [31:0] rsp_phys_o, fault_lin_o, dir_base_o, mem_addr_o;
	logic [31:0] mem_wdata_o, mem_rdata_i;
	logic [7:0]  rsp_vector_o;
	logic [15:0] rsp_err_o;
	logic [1:0]  mp;
	logic        flt, ce_i;

	ptu_paging_unit DUT (
		.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.req_valid_i(req_valid_i), .req_lin_i(req_lin_i),
		.req_write_i(req_write_i), .req_user_i(req_user_i),
		.req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
		.rsp_phys_o(rsp_phys_o), .rsp_fault_o(rsp_fault_o),
		.rsp_vector_o(rsp_vector_o), .rsp_err_o(rsp_err_o),
		.cr_wr_i(cr_wr_i), .cr_sel_i(cr_sel_i), .cr_wdata_i(cr_wdata_i),
		.fault_lin_o(fault_lin_o), .dir_base_o(dir_base_o),
		.mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_lock_o(mem_lock_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i)
	);
	ptu_mem_model u_mem (
		.clk_i(clk_i), .rstn_i(rstn_i), .mem_req_i(mem_req_o),
		.mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
		.mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
		.mem_rdata_o(mem_rdata_i)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic results;
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	task automatic crw(input ptu_cr_sel_e s, input logic [31:0] d);
		@(posedge clk_i);
		cr_wr_i    <= 1'b1;
		cr_sel_i   <= s;
		cr_wdata_i <= d;
		@(posedge clk_i);
		cr_wr_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask : crw

	// One translation; n ends as edges from take to answer
	task automatic xlat(input logic [31:0] a, input logic w, input logic u,
		input logic f, input logic [15:0] e);
		q.push_back({f, frm[19:0], a[11:0], e});
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_lin_i   <= a;
		req_write_i <= w;
		req_user_i  <= u;
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (!rsp_valid_o);
	endtask : xlat

	// Each answer is judged against the oldest expectation
	always @(negedge clk_i) begin
		if (rstn_i && rsp_valid_o) begin
			nt = q.pop_front();
			chk(32'(rsp_fault_o), 32'(nt.f));
			if (nt.f)
				chk(32'(rsp_err_o), 32'(nt.e));
			else
				chk(rsp_phys_o, nt.p);
		end
	end

	// Cut a hang short well after the expected run length
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			results();
		end
	end

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 6;
		cyc = 0;
		error_cnt = 0;
		comparisons = 0;
		rstn_i = 1'b0;
		req_valid_i = 1'b0;
		req_write_i = 1'b0;
		req_user_i = 1'b0;
		req_lin_i = 32'h0000_0000;
		cr_wr_i = 1'b0;
		ce_i = 1'b1;
		cr_sel_i = PTU_CR_FAULT_ADDR;
		cr_wdata_i = 32'h0000_0000;
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk(32'(req_ready_o), 32'h0000_0001);
		crw(PTU_CR_DIR_BASE, 32'h0000_1abc);
		chk(dir_base_o, 32'h0000_1000);
		// Tables edited only while no walk is in flight
		lin = 32'h0040_3000 | (32'($random(seed)) & 32'h0000_0fff);
		frm = 32'h0000_abca;
		u_mem.m[14'h0401] = 32'h0000_2e07;
		u_mem.m[14'h0803] = {frm[19:0], 12'he07};
		xlat(lin, 1'b0, 1'b1, 1'b0, 16'h0000);
		chk(u_mem.m[14'h0401], 32'h0000_2e27);
		chk(u_mem.m[14'h0803], {frm[19:0], 12'he27});
		xlat(lin, 1'b0, 1'b1, 1'b0, 16'h0000);
		chk(32'(n), 32'h0000_0001);
		xlat(lin, 1'b1, 1'b1, 1'b0, 16'h0000);
		chk(u_mem.m[14'h0803], {frm[19:0], 12'he67});
		u_mem.m[14'h0803] = 32'h1234_5e67;
		xlat(lin, 1'b1, 1'b1, 1'b0, 16'h0000);
		chk(32'(n), 32'h0000_0001);
		crw(PTU_CR_DIR_BASE, 32'h0000_1000);
		frm = 32'h0001_2345;
		xlat(lin, 1'b1, 1'b1, 1'b0, 16'h0000);
		chk(32'(n > 2), 32'h0000_0001);
		// Absent directory, then absent table entry
		u_mem.m[14'h0401] = 32'hffff_fffe;
		crw(PTU_CR_DIR_BASE, 32'h0000_1000);
		xlat(lin, 1'b1, 1'b1, 1'b1, 16'h0006);
		@(posedge clk_i);
		#1;
		chk(fault_lin_o, lin);
		chk(u_mem.m[14'h0401], 32'hffff_fffe);
		u_mem.m[14'h0401] = 32'h0000_2027;
		u_mem.m[14'h0807] = 32'hffff_fffe;
		lin = 32'h0040_7abc;
		xlat(lin, 1'b0, 1'b0, 1'b1, 16'h0000);
		@(posedge clk_i);
		#1;
		chk(fault_lin_o, lin);
		// Frozen clock enable drops a register write; then it lands
		@(posedge clk_i);
		ce_i <= 1'b0;
		crw(PTU_CR_FAULT_ADDR, 32'h5555_aaaa);
		chk(fault_lin_o, lin);
		@(posedge clk_i);
		ce_i <= 1'b1;
		crw(PTU_CR_FAULT_ADDR, 32'h5555_aaaa);
		chk(fault_lin_o, 32'h5555_aaaa);
		// Every pair of rights, read and write, both levels
		for (int k = 0; k < 64; k++) begin
			frm = 32'($random(seed));
			lin = {10'h001, 10'(k + 16), 12'($random(seed))};
			u_mem.m[14'h0401] = 32'h0000_2021 | {29'h0, k[1:0], 1'b0};
			u_mem.m[14'h0810 + 14'(k)] = {frm[19:0], 9'h030, k[3:2], 1'b1};
			mp = (k[1:0] < k[3:2]) ? k[1:0] : k[3:2];
			flt = k[5] && !(mp[1] && (!k[4] || mp[0]));
			xlat(lin, k[4], k[5], flt, {13'h0000, k[5], k[4], 1'b1});
		end
		// Read-only user page still cached: a user write faults on the hit
		xlat({10'h001, 10'h03a, 12'h123}, 1'b1, 1'b1, 1'b1, 16'h0007);
		chk(32'(n), 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		results();
	end
endmodule : two_level_page_translation_tlb_tb
`default_nettype wire
